/* File: verilog/host_port_pkg.sv */
// constants and types shared by the parallel host port design
package host_port_pkg;
    localparam int DATA_WIDTH = 8;
    localparam int PAGE_COUNT = 8;
    localparam int ROWS_PER_PAGE = 8;
    localparam int ROW_COUNT = PAGE_COUNT * ROWS_PER_PAGE;
    localparam int COLUMN_COUNT = 132;
    localparam int MEMORY_BITS = COLUMN_COUNT * ROW_COUNT;
    localparam int COL_ADDR_WIDTH = 8;
    localparam int ROW_ADDR_WIDTH = 6;
    localparam int PAGE_ADDR_WIDTH = 3;
    localparam int FIFO_DEPTH = 4;

    // command bytes
    localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
    localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
    localparam logic [7:0] CMD_COL_NORMAL = 8'hA0;
    localparam logic [7:0] CMD_COL_REVERSE = 8'hA1;
    localparam logic [7:0] CMD_ROW_NORMAL = 8'hC0;
    localparam logic [7:0] CMD_ROW_REVERSE = 8'hC8;
    localparam logic [4:0] CMD_PAGE_PREFIX = 5'h16;
    localparam logic [3:0] CMD_COL_LOW_PREFIX = 4'h0;
    localparam logic [3:0] CMD_COL_HIGH_PREFIX = 4'h1;

    localparam logic [7:0] COL_FIRST = 8'h00;
    localparam logic [7:0] COL_LAST = 8'h83;
    localparam logic [5:0] ROW_LAST = 6'h3F;

    // status byte layout
    localparam int STATUS_OFF_BIT = 6;
    localparam int STATUS_BUSY_BIT = 7;

    // timing
    localparam int CLOCK_KHZ = 125000;
    localparam int DISPLAY_ON_DELAY_MS = 100;
    localparam int DISPLAY_ON_DELAY_CYCLES = DISPLAY_ON_DELAY_MS * CLOCK_KHZ;
    localparam int ROW_SCAN_CYCLES = 16;

    typedef struct packed {
        logic isData;
        logic [DATA_WIDTH-1:0] value;
    } host_write_t;

    localparam int HOST_WRITE_WIDTH = $bits(host_write_t);
endpackage

/* File: verilog/fifo_buffer.sv */
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module fifo_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] writePtr;
    logic [AW:0] readPtr;
    wire [AW:0] fill = writePtr - readPtr;
    wire doPush = inValid && inReady;
    wire doPop = outValid && outReady;

    assign inReady = (fill != (AW+1)'(DEPTH));
    assign outValid = (fill != '0);
    assign outData = store[readPtr[AW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            writePtr <= '0;
            readPtr <= '0;
        end
        else
        begin
            if (doPush)
                writePtr <= writePtr + 1'b1;
            if (doPop)
                readPtr <= readPtr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (doPush)
            store[writePtr[AW-1:0]] <= inData;
    end
endmodule // fifo_buffer

/* File: verilog/oled_parallel_host_port.sv */
// parallel host port, display memory, remapping and panel scan
`timescale 1ns/1ns
module oled_parallel_host_port #(
    parameter int ON_DELAY_CYCLES = host_port_pkg::DISPLAY_ON_DELAY_CYCLES,
    parameter int ROW_CYCLES = host_port_pkg::ROW_SCAN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_n_in,
    input wire logic chipSelect_n,
    input wire logic writeStrobe_n,
    input wire logic readStrobe_n,
    input wire logic dataSelect,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] dataIn,
    output logic [host_port_pkg::DATA_WIDTH-1:0] dataOut,
    output logic dataOe,
    input wire logic display_off_pin,
    output logic writeBusy,
    output logic panelOn,
    output logic [host_port_pkg::ROW_COUNT-1:0] row_output,
    output logic [host_port_pkg::COLUMN_COUNT-1:0] column_output
);
    import host_port_pkg::*;

    // reset input low behaves as a full controller reset
    wire ctlReset = rst || !reset_n_in;

    // display memory: page x column bytes, D0 is the top row of a page
    logic [7:0] display_memory [PAGE_COUNT][COLUMN_COUNT];

    logic writeStrobePrev;
    logic readStrobePrev;
    logic colRemap;
    logic rowRemap;
    logic onPending;
    logic [31:0] onCount;
    logic [PAGE_ADDR_WIDTH-1:0] pageAddr;
    logic [COL_ADDR_WIDTH-1:0] colAddr;
    logic [ROW_ADDR_WIDTH-1:0] rowIndex;
    logic [15:0] rowTimer;

    // host write capture
    wire selected = !chipSelect_n;
    wire writeEdge = selected && writeStrobePrev && !writeStrobe_n;
    wire readActive = selected && !readStrobe_n;
    wire readEnd = selected && !readStrobePrev && readStrobe_n;

    host_write_t captured;
    host_write_t pending;
    wire fifoInReady;
    wire fifoOutValid;
    wire rowTick = (rowTimer == 16'(ROW_CYCLES - 1));
    // memory is frozen for the cycle the scan latches a row
    wire drainReady = !rowTick;
    wire drain = fifoOutValid && drainReady;

    assign captured.isData = dataSelect;
    assign captured.value = dataIn;

    fifo_buffer #(
        .WIDTH(HOST_WRITE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) writeQueue (
        .ref_clk(ref_clk),
        .rst(ctlReset),
        .inValid(writeEdge),
        .inReady(fifoInReady),
        .inData(captured),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(pending)
    );

    // command decode
    wire isCmd = drain && !pending.isData;
    wire isMemWrite = drain && pending.isData;
    wire [7:0] cmdByte = pending.value;
    wire cmdOn = isCmd && (cmdByte == CMD_DISPLAY_ON);
    wire cmdOff = isCmd && (cmdByte == CMD_DISPLAY_OFF);
    wire cmdColNormal = isCmd && (cmdByte == CMD_COL_NORMAL);
    wire cmdColReverse = isCmd && (cmdByte == CMD_COL_REVERSE);
    wire cmdRowNormal = isCmd && (cmdByte == CMD_ROW_NORMAL);
    wire cmdRowReverse = isCmd && (cmdByte == CMD_ROW_REVERSE);
    wire cmdPage = isCmd && (cmdByte[7:3] == CMD_PAGE_PREFIX);
    wire cmdColLow = isCmd && (cmdByte[7:4] == CMD_COL_LOW_PREFIX);
    wire cmdColHigh = isCmd && (cmdByte[7:4] == CMD_COL_HIGH_PREFIX);

    // column pointer advances after each memory write or memory read
    wire readAdvance = readEnd && dataSelect;
    wire advance = isMemWrite || readAdvance;
    wire [COL_ADDR_WIDTH-1:0] next_colAdvance =
        (colAddr >= COL_LAST) ? COL_FIRST : colAddr + 1'b1;
    wire colValid = (colAddr <= COL_LAST);

    wire [7:0] memReadByte =
        colValid ? display_memory[pageAddr][colAddr] : '0;
    // busy and display-off flags at their named bit positions
    wire [7:0] statusByte = (8'(!fifoInReady) << STATUS_BUSY_BIT)
        | (8'(!panelOn) << STATUS_OFF_BIT);
    wire [7:0] next_dataOut = dataSelect ? memReadByte : statusByte;

    // scan mapping: memory row for the current row output
    wire [ROW_ADDR_WIDTH-1:0] memRow =
        rowRemap ? ROW_LAST - rowIndex : rowIndex;
    wire [PAGE_ADDR_WIDTH-1:0] scanPage = memRow[5:3];
    wire [2:0] scanBit = memRow[2:0];
    wire [COLUMN_COUNT-1:0] colBit;
    wire [ROW_COUNT-1:0] rowSelect;
    wire blank = !panelOn || display_off_pin;

    genvar c;
    generate
        for (c = 0; c < COLUMN_COUNT; c++)
        begin : g_column
            // column output c reads address c, or 131 - c when reversed
            assign colBit[c] = colRemap
                ? display_memory[scanPage][COLUMN_COUNT-1-c][scanBit]
                : display_memory[scanPage][c][scanBit];
        end
    endgenerate

    assign rowSelect = ROW_COUNT'(1) << rowIndex;

    // strobe history
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            writeStrobePrev <= 1'b1;
            readStrobePrev <= 1'b1;
        end
        else
        begin
            writeStrobePrev <= writeStrobe_n;
            readStrobePrev <= readStrobe_n;
        end
    end

    // memory byte store
    always_ff @(posedge ref_clk)
    begin
        if (isMemWrite && colValid)
            display_memory[pageAddr][colAddr] <= pending.value;
    end

    // remap selects
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            colRemap <= 1'b0;
            rowRemap <= 1'b0;
        end
        else
        begin
            if (cmdColNormal || cmdColReverse)
                colRemap <= cmdColReverse;
            if (cmdRowNormal || cmdRowReverse)
                rowRemap <= cmdRowReverse;
        end
    end

    // page and column pointers
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            pageAddr <= '0;
            colAddr <= COL_FIRST;
        end
        else
        begin
            if (cmdPage)
                pageAddr <= cmdByte[PAGE_ADDR_WIDTH-1:0];
            if (cmdColLow)
                colAddr <= {colAddr[7:4], cmdByte[3:0]};
            else if (cmdColHigh)
                colAddr <= {cmdByte[3:0], colAddr[3:0]};
            else if (advance)
                colAddr <= next_colAdvance;
        end
    end

    // display on after the fixed delay, off at once
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            onPending <= 1'b0;
            onCount <= '0;
            panelOn <= 1'b0;
        end
        else if (cmdOff)
        begin
            onPending <= 1'b0;
            onCount <= '0;
            panelOn <= 1'b0;
        end
        else if (cmdOn && !panelOn)
        begin
            onPending <= 1'b1;
            onCount <= '0;
        end
        else if (onPending)
        begin
            if (onCount == 32'(ON_DELAY_CYCLES - 1))
            begin
                onPending <= 1'b0;
                panelOn <= 1'b1;
            end
            else
                onCount <= onCount + 1'b1;
        end
    end

    // read data drive
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            dataOe <= 1'b0;
            dataOut <= '0;
            writeBusy <= 1'b0;
        end
        else
        begin
            dataOe <= readActive;
            dataOut <= next_dataOut;
            writeBusy <= !fifoInReady;
        end
    end

    // row scan timer
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            rowTimer <= '0;
            rowIndex <= '0;
        end
        else if (rowTick)
        begin
            rowTimer <= '0;
            rowIndex <= rowIndex + 1'b1;
        end
        else
            rowTimer <= rowTimer + 1'b1;
    end

    // panel drive latched once per row
    always_ff @(posedge ref_clk)
    begin
        if (ctlReset)
        begin
            row_output <= '0;
            column_output <= '0;
        end
        else if (rowTick)
        begin
            row_output <= blank ? '0 : rowSelect;
            column_output <= blank ? '0 : colBit;
        end
    end
endmodule // oled_parallel_host_port

/* File: sim/host_model.sv */
// host side of the eight-bit parallel bus
`timescale 1ns/1ns
module host_model #(
    // logic supply kept this many cycles after display supply removal
    parameter int OFF_WAIT_CYCLES = 10000000
) (
    input wire logic ref_clk,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] dataOut,
    input wire logic dataOe,
    output logic reset_n_in,
    output logic chipSelect_n,
    output logic writeStrobe_n,
    output logic readStrobe_n,
    output logic dataSelect,
    output logic [host_port_pkg::DATA_WIDTH-1:0] dataIn
);
    import host_port_pkg::*;
    initial
    begin
        reset_n_in = 1'b1;
        chipSelect_n = 1'b1;
        writeStrobe_n = 1'b1;
        readStrobe_n = 1'b1;
        dataSelect = 1'b0;
        dataIn = 8'h00;
    end
    task automatic wr(input logic ds, input logic [7:0] b);
        @(posedge ref_clk);
        chipSelect_n <= 1'b0;
        dataSelect <= ds;
        dataIn <= b;
        writeStrobe_n <= 1'b0;
        @(posedge ref_clk);
        writeStrobe_n <= 1'b1;
        chipSelect_n <= 1'b1;
        // released bus shows the inverse of the last byte
        dataIn <= ~b;
    endtask
    task automatic rd(input logic ds, output logic [7:0] b);
        @(posedge ref_clk);
        chipSelect_n <= 1'b0;
        dataSelect <= ds;
        readStrobe_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        b = dataOe ? dataOut : 8'hXX;
        readStrobe_n <= 1'b1;
        @(posedge ref_clk);
        chipSelect_n <= 1'b1;
    endtask
    task automatic powerDown();
        wr(1'b0, CMD_DISPLAY_OFF);
        // display supply drops here, logic supply waits before going
        repeat (OFF_WAIT_CYCLES) @(posedge ref_clk);
    endtask
    task automatic resetPulse();
        @(posedge ref_clk);
        reset_n_in <= 1'b0;
        // 3 us at 8 ns per cycle, also the wait before supply enable
        repeat (375) @(posedge ref_clk);
        reset_n_in <= 1'b1;
        @(posedge ref_clk);
    endtask
endmodule // host_model

/* File: sim/oled_parallel_host_port_asserts.sv */
// concurrent checks on the parallel host port outputs
`timescale 1ns/1ns
module oled_parallel_host_port_asserts #(
    parameter int ON_DELAY_CYCLES = host_port_pkg::DISPLAY_ON_DELAY_CYCLES,
    parameter int ROW_CYCLES = host_port_pkg::ROW_SCAN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_n_in,
    input wire logic chipSelect_n,
    input wire logic writeStrobe_n,
    input wire logic readStrobe_n,
    input wire logic dataSelect,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] dataIn,
    input wire logic [host_port_pkg::DATA_WIDTH-1:0] dataOut,
    input wire logic dataOe,
    input wire logic display_off_pin,
    input wire logic writeBusy,
    input wire logic panelOn,
    input wire logic [host_port_pkg::ROW_COUNT-1:0] row_output,
    input wire logic [host_port_pkg::COLUMN_COUNT-1:0] column_output
);
    import host_port_pkg::*;
    localparam int BLANK_MAX = 40;
    int offCount;
    always_ff @(posedge ref_clk)
    begin
        if (rst || !display_off_pin)
            offCount <= 0;
        else if (offCount < 1000)
            offCount <= offCount + 1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !reset_n_in);
    property p_resetClear;
        disable iff (1'b0) rst |=> !panelOn && !dataOe && !writeBusy;
    endproperty
    a_resetClear: assert property (p_resetClear)
        else $error("outputs not cleared by reset");
    property p_readDrive;
        !chipSelect_n && !readStrobe_n |=> dataOe;
    endproperty
    a_readDrive: assert property (p_readDrive)
        else $error("bus not driven during read");
    property p_readRelease;
        chipSelect_n || readStrobe_n |=> !dataOe;
    endproperty
    a_readRelease: assert property (p_readRelease)
        else $error("bus driven outside read");
    property p_statusZero;
        dataOe && !$past(dataSelect) |-> dataOut[5:0] == 6'h00;
    endproperty
    a_statusZero: assert property (p_statusZero)
        else $error("status low bits not zero");
    property p_blankAfterOff;
        $fell(panelOn) |-> ##[1:BLANK_MAX] row_output == '0;
    endproperty
    a_blankAfterOff: assert property (p_blankAfterOff)
        else $error("rows still active after panel off");
    property p_oneRow;
        $onehot0(row_output);
    endproperty
    a_oneRow: assert property (p_oneRow)
        else $error("more than one row active");
    property p_colFollowsRow;
        row_output == '0 |-> column_output == '0;
    endproperty
    a_colFollowsRow: assert property (p_colFollowsRow)
        else $error("columns active with no row");
    property p_pinBlank;
        offCount > ROW_CYCLES + 1 |-> row_output == '0;
    endproperty
    a_pinBlank: assert property (p_pinBlank)
        else $error("rows active while off pin high");
    c_panelOn: cover property ($rose(panelOn));
    c_read: cover property ($rose(dataOe));
    c_pin: cover property (offCount > ROW_CYCLES + 1);
endmodule // oled_parallel_host_port_asserts
bind oled_parallel_host_port oled_parallel_host_port_asserts #(
    .ON_DELAY_CYCLES(ON_DELAY_CYCLES),
    .ROW_CYCLES(ROW_CYCLES)
) chk_u (.ref_clk, .rst, .reset_n_in, .chipSelect_n, .writeStrobe_n,
    .readStrobe_n, .dataSelect, .dataIn, .dataOut, .dataOe,
    .display_off_pin, .writeBusy, .panelOn, .row_output, .column_output);

/* File: sim/oled_parallel_host_port_tb.sv */
// self-checking bench for the parallel host port
`timescale 1ns/1ns
module oled_parallel_host_port_tb;
    import host_port_pkg::*;
    localparam int ON_CYCLES = 20;
    localparam int ROWC = 4;
    localparam logic [7:0] PATTERN [4] = '{8'h00, 8'h81, 8'h5A, 8'hC3};
    localparam logic [7:0] COL_CMD [4] = '{8'hA0, 8'hA0, 8'hA1, 8'hA1};
    localparam logic [7:0] ROW_CMD [4] = '{8'hC0, 8'hC0, 8'hC0, 8'hC8};
    localparam int ROW_IDX [4] = '{0, 7, 0, 63};
    localparam logic [3:0] EDGE_BITS [4] = '{4'hA, 4'hA, 4'h5, 4'h5};
    logic ref_clk, rst, display_off_pin, reset_n_in, chipSelect_n;
    logic writeStrobe_n, readStrobe_n, dataSelect, dataOe, writeBusy;
    logic panelOn;
    logic [7:0] dataIn, dataOut;
    logic [ROW_COUNT-1:0] row_output;
    logic [COLUMN_COUNT-1:0] column_output;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    // supply-off wait shortened to keep the run brief
    host_model #(.OFF_WAIT_CYCLES(8)) host_u (.ref_clk, .dataOut,
        .dataOe, .reset_n_in, .chipSelect_n, .writeStrobe_n,
        .readStrobe_n, .dataSelect, .dataIn);
    oled_parallel_host_port #(.ON_DELAY_CYCLES(ON_CYCLES),
        .ROW_CYCLES(ROWC)) dut_u (.ref_clk, .rst, .reset_n_in,
        .chipSelect_n, .writeStrobe_n, .readStrobe_n, .dataSelect, .dataIn,
        .dataOut, .dataOe, .display_off_pin, .writeBusy, .panelOn,
        .row_output, .column_output);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic checkValue(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic setCol(input logic [7:0] c);
        host_u.wr(1'b0, 8'hB0);
        host_u.wr(1'b0, {4'h0, c[3:0]});
        host_u.wr(1'b0, {4'h1, c[7:4]});
    endtask
    task automatic checkStatus(input logic [7:0] exp);
        logic [7:0] v;
        host_u.rd(1'b0, v);
        checkValue("status", exp, v);
    endtask
    task automatic testMemory();
        logic [7:0] v;
        setCol(8'h82);
        foreach (PATTERN[i]) host_u.wr(1'b1, PATTERN[i]);
        #1;
        checkValue("writeBusy", 8'h00, {7'h00, writeBusy});
        setCol(8'h82);
        foreach (PATTERN[i])
        begin
            host_u.rd(1'b1, v);
            checkValue("memory", PATTERN[i], v);
        end
    endtask
    task automatic testDisplayOn();
        int n;
        n = 0;
        host_u.wr(1'b0, CMD_DISPLAY_ON);
        while (panelOn !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        checkValue("onDelay", 8'h01,
            8'(n >= ON_CYCLES + 1 && n <= ON_CYCLES + 4));
    endtask
    task automatic testRemap();
        bit gap;
        foreach (COL_CMD[i])
        begin
            host_u.wr(1'b0, COL_CMD[i]);
            host_u.wr(1'b0, ROW_CMD[i]);
            gap = 0;
            repeat (600)
            begin
                @(posedge ref_clk);
                #1;
                if (row_output[ROW_IDX[i]] !== 1'b1)
                    gap = 1;
                else if (gap)
                    break;
            end
            checkValue("columns", {4'h0, EDGE_BITS[i]}, {4'h0,
                column_output[131], column_output[130], column_output[1],
                column_output[0]});
        end
    endtask
    task automatic testBlanking();
        logic [7:0] v;
        @(posedge ref_clk);
        display_off_pin <= 1'b1;
        repeat (ROWC + 3) @(posedge ref_clk);
        #1;
        checkValue("pinBlank", 8'h00, 8'(row_output != '0));
        @(posedge ref_clk);
        display_off_pin <= 1'b0;
        host_u.powerDown();
        repeat (ROWC + 4) @(posedge ref_clk);
        #1;
        checkValue("panelOn", 8'h00, {7'h00, panelOn});
        checkStatus(8'h40);
        host_u.resetPulse();
        host_u.rd(1'b1, v);
        checkValue("memoryKept", 8'h5A, v);
        checkStatus(8'h40);
    endtask
    initial
    begin
        rst = 1'b1;
        display_off_pin = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        checkValue("resetRows", 8'h00, 8'(row_output != '0));
        checkStatus(8'h40);
        testMemory();
        testDisplayOn();
        testRemap();
        testBlanking();
        tally_and_finish();
    end
endmodule // oled_parallel_host_port_tb
